// >>> core/reset_stretch.sv
// Delay counter that stretches the internal reset after all sources release
`timescale 1ns/100ps
`include "sleep_power_map.svh"
module reset_stretch import sleep_power_pkg::*; #(
  parameter logic [21:0] TOUT_SHORT = 22'(`TOUT_CYC(`TOUT_SHORT_US)),
  parameter logic [21:0] TOUT_LONG = 22'(`TOUT_CYC(`TOUT_LONG_US))
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Reset sources and fuses
  input wire logic resetSrcAny,
  input wire logic [1:0] startupTimeFuses,
  input wire logic [1:0] clockSelFuses,
  // Stretched reset
  output logic internalReset,
  output logic resumeAtVector
);
  logic [21:0] delayCnt_r;
  logic stretch_r;

  function automatic logic [21:0] toutCycles(input logic [1:0] startup_time_fuses, input logic [1:0] clock_select_fuses);
    logic [21:0] base;
    base = 22'h1;
    case (startup_time_fuses)
      2'h0: base = 22'h1;
      2'h1: base = TOUT_SHORT;
      default: base = TOUT_LONG;
    endcase
    // Slow-starting clock sources get an extra short span on top
    if (clock_select_fuses[1]) begin
      base = base + TOUT_SHORT;
    end
    return base;
  endfunction : toutCycles

  always_ff @(posedge core_clk) begin
    if (reset || resetSrcAny) begin
      stretch_r <= 1'b1;
      delayCnt_r <= toutCycles(startupTimeFuses, clockSelFuses);
    end else if (delayCnt_r > 22'h1) begin
      delayCnt_r <= delayCnt_r - 22'h1;
    end else begin
      delayCnt_r <= 22'h0;
      stretch_r <= 1'b0;
    end
  end

  assign internalReset = stretch_r;
  assign resumeAtVector = stretch_r && delayCnt_r <= 22'h1 && !resetSrcAny && !reset;

  property p_stretch_holds;
    @(posedge core_clk) disable iff (reset)
    $fell(resetSrcAny) |-> internalReset;
  endproperty
  a_stretch_holds: assert property (p_stretch_holds)
    else $error("internal reset dropped with the reset source");
endmodule : reset_stretch

// >>> core/sleep_power_control.sv
// Sleep mode, brown-out sleep disable, clock gating and reset control with AXI4-Lite registers
// Functional notes
// - Arm brown-out off: write both, then off-only
// - Off bit takes effect three cycles later
// - Hardware clears off bit after three cycles
// - Detector off only if sleep while active
// - Sleep only when sleep enable bit set
// - Mode field: idle, noise, power-down, reserved
// - Reserved bits read as zero
// - Timer gate freezes timer, resumes unchanged
// - Converter gate stops clock, comparator unavailable
// - Reset loads initial values, restart at vector
// - Ports reset at once, without clock
// - Delay counter stretches internal reset
// - Converter stays on in sleep; extended conversion; code stops its clock in power-down
// - Power-down disables comparator unless using reference
// - Input buffers off when both clocks stopped; code does it in power-down only, keeping wake inputs on
// - Fuse-enabled detector stays on in sleep
// - Enabled watchdog keeps running in sleep
// - Reference on when any user needs it
// - Detector re-enabled on wake before execution
// - Gated peripheral frozen, register access blocked
`timescale 1ns/100ps
`include "sleep_power_map.svh"
module sleep_power_control import sleep_power_pkg::*; #(
  parameter logic [21:0] TOUT_SHORT = 22'(`TOUT_CYC(`TOUT_SHORT_US)),
  parameter logic [21:0] TOUT_LONG = 22'(`TOUT_CYC(`TOUT_LONG_US))
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Processor core
  input wire logic sleepInstr,
  input wire logic wakeEvent,
  output logic cpuHalt,
  output logic resumeAtVector,
  // Reset sources and fuses
  input wire logic resetSrcAny,
  input wire logic [1:0] startupTimeFuses,
  input wire logic [1:0] clockSelFuses,
  input wire logic brownoutLevelFusesOn,
  output logic internalReset,
  output logic ioPortReset,
  // Peripheral status in
  input wire logic converterEnabled,
  input wire logic convStart,
  input wire logic comparatorWanted,
  input wire logic comparatorUsesRef,
  input wire logic watchdogEnabled,
  input wire logic [5:0] wakeInputNeeded,
  // Clock and power controls out
  output logic cpuClkEn,
  output logic ioClkEn,
  output logic mainOscEn,
  output logic timerClkEn,
  output logic converterClkEn,
  output logic timerRegAccessOk,
  output logic converterRegAccessOk,
  output logic comparatorEnable,
  output logic extendedConvNext,
  output logic bodEnable,
  output logic refEnable,
  output logic watchdogRun,
  output logic [5:0] inputBufEn,
  output logic pullupGlobalOff,
  output logic [1:0] extIrqSense
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  localparam logic [11:0] WAKE_CYC = 12'(`BOD_WAKE_CYCLES);

  logic regRst;
  logic [7:0] slpCtl_r, gate_r;
  logic [2:0] unlockLeft_r, bodsAge_r;
  logic awHeld_r, wHeld_r, bvalid_r, rvalid_r;
  logic [7:0] awAddr_r, wData_r, rByte_r;
  logic wLane_r;
  logic [1:0] bresp_r, rresp_r;
  logic wrEv, wrBod, bodsBit, bodsActive;
  pwr_state_t state_r, state_nxt;
  sleep_mode_t mode_r;
  logic bodOff_r, extConv_r, convEnPrev_r;
  logic [11:0] wakeCnt_r;
  logic asleepPd, asleepNoise, asleepAny;

  function automatic logic isMapped(input logic [7:0] a);
    return a == `REG_BOD_OFS || a == `REG_SLP_OFS || a == `REG_GATE_OFS || a == `REG_STAT_OFS;
  endfunction : isMapped

  function automatic sleep_mode_t decodeMode(input logic [7:0] ctl);
    return sleep_mode_t'({ctl[`SM_HI], ctl[`SM_LO]});
  endfunction : decodeMode

  reset_stretch #(
    .TOUT_SHORT(TOUT_SHORT),
    .TOUT_LONG(TOUT_LONG)
  ) reset_stretch_i (
    .core_clk(core_clk),
    .reset(reset),
    .resetSrcAny(resetSrcAny),
    .startupTimeFuses(startupTimeFuses),
    .clockSelFuses(clockSelFuses),
    .internalReset(internalReset),
    .resumeAtVector(resumeAtVector)
  );

  // Registers return to initial values for the whole stretched reset
  assign regRst = reset || internalReset;
  // Pure combinational path so the ports go safe even with no clock
  assign ioPortReset = resetSrcAny || internalReset;

  // Write channel: address and data taken in either order
  assign awready = !awHeld_r && !bvalid_r;
  assign wready = !wHeld_r && !bvalid_r;
  assign wrEv = awHeld_r && wHeld_r && !bvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 8'h00;
      wLane_r <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end else if (wrEv) begin
        awHeld_r <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata[7:0];
        wLane_r <= wstrb[0];
      end else if (wrEv) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (wrEv) begin
      bvalid_r <= 1'b1;
      bresp_r <= isMapped(awAddr_r) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel: one outstanding read
  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = {24'h000000, rByte_r};
  assign rresp = rresp_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rByte_r <= 8'h00;
      rresp_r <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= isMapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (araddr)
        `REG_BOD_OFS: rByte_r <= {6'h00, bodsBit, unlockLeft_r != 3'h0} & `BOD_RD_MASK;
        `REG_SLP_OFS: rByte_r <= slpCtl_r & `SLP_RD_MASK;
        `REG_GATE_OFS: rByte_r <= gate_r & `GATE_RD_MASK;
        `REG_STAT_OFS: rByte_r <= {2'h0, bodsActive, extConv_r, bodOff_r, mode_r, asleepAny};
        default: rByte_r <= 8'h00;
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Control and clock-gate registers
  always_ff @(posedge core_clk) begin
    if (regRst) begin
      slpCtl_r <= `REG_RESET;
      gate_r <= `REG_RESET;
    end else if (wrEv && wLane_r) begin
      if (awAddr_r == `REG_SLP_OFS) begin
        slpCtl_r <= wData_r & `SLP_RD_MASK;
      end
      if (awAddr_r == `REG_GATE_OFS) begin
        gate_r <= wData_r & `GATE_RD_MASK;
      end
    end
  end

  assign pullupGlobalOff = slpCtl_r[`PUD_BIT];
  assign extIrqSense = {slpCtl_r[`ISC_HI], slpCtl_r[`ISC_LO]};

  // Brown-out sleep-off timed sequence
  assign wrBod = wrEv && wLane_r && awAddr_r == `REG_BOD_OFS;

  always_ff @(posedge core_clk) begin
    if (regRst) begin
      unlockLeft_r <= 3'h0;
    end else if (wrBod && wData_r[`BOD_OFF_BIT] && wData_r[`BOD_UNLK_BIT]) begin
      unlockLeft_r <= `BOD_UNLOCK_CYCLES;
    end else if (unlockLeft_r != 3'h0) begin
      unlockLeft_r <= unlockLeft_r - 3'h1;
    end
  end

  // Age 1..3 the bit reads set, 4..6 it is in force, then gone
  always_ff @(posedge core_clk) begin
    if (regRst) begin
      bodsAge_r <= 3'h0;
    end else if (wrBod && wData_r[`BOD_OFF_BIT] && !wData_r[`BOD_UNLK_BIT]
                 && unlockLeft_r != 3'h0) begin
      bodsAge_r <= 3'h1;
    end else if (bodsAge_r == `BROWNOUT_SLEEP_OFF_AGE_END) begin
      bodsAge_r <= 3'h0;
    end else if (bodsAge_r != 3'h0) begin
      bodsAge_r <= bodsAge_r + 3'h1;
    end
  end

  assign bodsBit = bodsAge_r != 3'h0 && bodsAge_r <= `BROWNOUT_SLEEP_OFF_SET_SPAN;
  assign bodsActive = bodsAge_r > `BROWNOUT_SLEEP_OFF_SET_SPAN;

  // Sleep state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_ACTIVE: begin
        if (sleepInstr && slpCtl_r[`SE_BIT] && decodeMode(slpCtl_r) != MODE_RSVD) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wakeEvent) begin
          state_nxt = bodOff_r ? ST_WAKE : ST_ACTIVE;
        end
      end
      ST_WAKE: begin
        if (wakeCnt_r == 12'h000) begin
          state_nxt = ST_ACTIVE;
        end
      end
      default: state_nxt = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (regRst) begin
      state_r <= ST_ACTIVE;
      mode_r <= MODE_IDLE;
      bodOff_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_ACTIVE && state_nxt == ST_SLEEP) begin
        mode_r <= decodeMode(slpCtl_r);
        bodOff_r <= bodsActive;
      end else if (state_r == ST_WAKE && state_nxt == ST_ACTIVE) begin
        bodOff_r <= 1'b0;
      end
    end
  end

  // Detector needs settling time before code runs again
  always_ff @(posedge core_clk) begin
    if (regRst) begin
      wakeCnt_r <= 12'h000;
    end else if (state_r == ST_SLEEP && wakeEvent) begin
      wakeCnt_r <= WAKE_CYC - 12'h001;
    end else if (wakeCnt_r != 12'h000) begin
      wakeCnt_r <= wakeCnt_r - 12'h001;
    end
  end

  assign asleepAny = state_r == ST_SLEEP;
  assign asleepPd = asleepAny && mode_r == MODE_PDOWN;
  assign asleepNoise = asleepAny && mode_r == MODE_NOISE;

  assign cpuHalt = state_r != ST_ACTIVE || internalReset;
  assign cpuClkEn = !cpuHalt;
  assign ioClkEn = !(asleepPd || asleepNoise);
  assign mainOscEn = !asleepPd;
  // Frozen clocks keep peripheral state intact across the gate
  assign timerClkEn = ioClkEn && !gate_r[`TIMER_GATE_BIT];
  assign converterClkEn = !asleepPd && !gate_r[`CONV_GATE_BIT];
  assign timerRegAccessOk = !gate_r[`TIMER_GATE_BIT];
  assign converterRegAccessOk = !gate_r[`CONV_GATE_BIT];
  assign comparatorEnable = comparatorWanted && !gate_r[`CONV_GATE_BIT]
                            && !(asleepPd && !comparatorUsesRef);
  // Fuse-enabled detector stays on, except the armed sleep
  assign bodEnable = brownoutLevelFusesOn && !(asleepAny && bodOff_r);
  assign refEnable = bodEnable || (comparatorEnable && comparatorUsesRef)
                     || converterEnabled;
  assign watchdogRun = watchdogEnabled;
  assign inputBufEn = (asleepPd && !converterClkEn) ? wakeInputNeeded : 6'h3f;

  // Re-enabled converter owes an extended conversion; set wins over clear
  always_ff @(posedge core_clk) begin
    if (regRst) begin
      convEnPrev_r <= 1'b0;
      extConv_r <= 1'b1;
    end else begin
      convEnPrev_r <= converterEnabled;
      if (converterEnabled && !convEnPrev_r) begin
        extConv_r <= 1'b1;
      end else if (convStart) begin
        extConv_r <= 1'b0;
      end
    end
  end
  assign extendedConvNext = extConv_r;

  property p_brownout_sleep_off_clear;
    $rose(bodsBit) |-> bodsBit [*3] ##1 !bodsBit;
  endproperty
  a_brownout_sleep_off_clear: assert property (p_brownout_sleep_off_clear)
    else $error("sleep-off bit not cleared after three cycles");

  property p_brownout_sleep_off_delay;
    $rose(bodsBit) |-> !bodsActive [*3] ##1 bodsActive;
  endproperty
  a_brownout_sleep_off_delay: assert property (p_brownout_sleep_off_delay)
    else $error("sleep-off not in force three cycles after set");

  property p_late_write;
    wrBod && wData_r[`BOD_OFF_BIT] && !wData_r[`BOD_UNLK_BIT] && unlockLeft_r == 3'h0
      && bodsAge_r == 3'h0 && !regRst |=> bodsAge_r == 3'h0;
  endproperty
  a_late_write: assert property (p_late_write)
    else $error("sleep-off set without open window");

  property p_no_se;
    state_r == ST_ACTIVE && sleepInstr && !slpCtl_r[`SE_BIT] && !regRst
      |=> state_r == ST_ACTIVE;
  endproperty
  a_no_se: assert property (p_no_se)
    else $error("sleep entered with enable bit clear");

  property p_rsvd_mode;
    state_r == ST_ACTIVE && sleepInstr && decodeMode(slpCtl_r) == MODE_RSVD && !regRst
      |=> !asleepAny;
  endproperty
  a_rsvd_mode: assert property (p_rsvd_mode)
    else $error("reserved mode produced a sleep");

  property p_pdown_clocks;
    asleepPd |-> !mainOscEn && !ioClkEn && !converterClkEn
      && (inputBufEn[0] == wakeInputNeeded[0]);
  endproperty
  a_pdown_clocks: assert property (p_pdown_clocks)
    else $error("power-down left a clock or buffer on");

  property p_bod_off_cause;
    $rose(bodOff_r) |-> $past(sleepInstr) && $past(bodsActive) && asleepAny;
  endproperty
  a_bod_off_cause: assert property (p_bod_off_cause)
    else $error("detector switched off without armed sleep");

  property p_wake_bod;
    state_r == ST_WAKE |-> cpuHalt && bodEnable == brownoutLevelFusesOn;
  endproperty
  a_wake_bod: assert property (p_wake_bod)
    else $error("detector not back on while waking");

  property p_timer_gate;
    gate_r[`TIMER_GATE_BIT] |-> !timerClkEn && !timerRegAccessOk;
  endproperty
  a_timer_gate: assert property (p_timer_gate)
    else $error("gated timer still clocked or accessible");

  property p_port_reset;
    resetSrcAny |-> ioPortReset ##1 internalReset;
  endproperty
  a_port_reset: assert property (p_port_reset)
    else $error("ports not held in reset");
endmodule : sleep_power_control

// >>> core/sleep_power_map.svh
// Register offsets, field positions and timing counts of the sleep and power controller
`ifndef SLEEP_POWER_MAP_SVH
`define SLEEP_POWER_MAP_SVH
`define REG_BOD_OFS 8'h00
`define REG_SLP_OFS 8'h04
`define REG_GATE_OFS 8'h08
`define REG_STAT_OFS 8'h0c
`define BOD_OFF_BIT 1
`define BOD_UNLK_BIT 0
`define PUD_BIT 6
`define SE_BIT 5
`define SM_HI 4
`define SM_LO 3
`define ISC_HI 1
`define ISC_LO 0
`define TIMER_GATE_BIT 1
`define CONV_GATE_BIT 0
`define BOD_RD_MASK 8'h03
`define SLP_RD_MASK 8'h7b
`define GATE_RD_MASK 8'h03
`define REG_RESET 8'h00
`define BOD_UNLOCK_CYCLES 3'h4
`define BROWNOUT_SLEEP_OFF_SET_SPAN 3'h3
`define BROWNOUT_SLEEP_OFF_AGE_END 3'h6
`define CLK_PERIOD_NS 25
`define BOD_WAKE_NS 60000
`define BOD_WAKE_CYCLES ((`BOD_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TOUT_SHORT_US 4
`define TOUT_LONG_US 64000
`define TOUT_CYC(us) (((us) * 1000) / `CLK_PERIOD_NS)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> core/sleep_power_pkg.sv
// Types shared by the sleep and power controller
package sleep_power_pkg;
  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_NOISE = 2'h1,
    MODE_PDOWN = 2'h2,
    MODE_RSVD = 2'h3
  } sleep_mode_t;
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0,
    ST_SLEEP = 2'h1,
    ST_WAKE = 2'h3
  } pwr_state_t;
endpackage : sleep_power_pkg

// >>> tb/core_model.sv
// Processor core model that issues sleep instructions and wake events
`timescale 1ns/100ps
module core_model (
  // Clock
  input wire logic core_clk,
  // Toward the controller
  output logic sleepInstr,
  output logic wakeEvent
);
  initial begin
    sleepInstr = 1'b0;
    wakeEvent = 1'b0;
  end
  // One-cycle pulse, changed only just after an edge
  task automatic sleep_now();
    @(posedge core_clk);
    sleepInstr <= 1'b1;
    @(posedge core_clk);
    sleepInstr <= 1'b0;
  endtask : sleep_now
  task automatic wake_now();
    @(posedge core_clk);
    wakeEvent <= 1'b1;
    @(posedge core_clk);
    wakeEvent <= 1'b0;
  endtask : wake_now
endmodule : core_model

// >>> tb/sleep_power_control_tb.sv
// Self-checking bench for the sleep and power controller
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
  begin checked++; if ((gt) !== (ex)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module sleep_power_control_tb;
  import sleep_power_pkg::*;
  logic core_clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sleepInstr, wakeEvent, cpuHalt, resumeAtVector;
  logic resetSrcAny, brownoutLevelFusesOn, internalReset, ioPortReset, converterEnabled;
  logic convStart, comparatorWanted, comparatorUsesRef, watchdogEnabled, cpuClkEn, ioClkEn;
  logic mainOscEn, timerClkEn, converterClkEn, timerRegAccessOk, converterRegAccessOk;
  logic comparatorEnable, extendedConvNext, bodEnable, refEnable, watchdogRun, pullupGlobalOff;
  logic [7:0] awaddr, araddr, r;
  logic [31:0] wdata, rdata, lastRd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, startupTimeFuses, clockSelFuses, extIrqSense, md;
  logic [5:0] wakeInputNeeded, inputBufEn;
  logic [1:0] bq[$];
  logic [1:0] eb;
  logic [34:0] rq[$];
  logic [34:0] e;
  logic se, slp, seen, rv;
  int n, checked, fail_count;

  // Short stretch counts keep the run brief
  sleep_power_control #(.TOUT_SHORT(22'd4), .TOUT_LONG(22'd10)) sleep_power_control_i (.*);
  core_model core_model_i (.core_clk(core_clk), .sleepInstr(sleepInstr), .wakeEvent(wakeEvent));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic tick();
    n++;
    if (n > 100) begin
      fail_count++;
      $display("[FAIL] wait expected done seen timeout");
      summarize();
    end
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs);
    bq.push_back(rs);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) bready <= 1'b0;
      tick();
    end while (bready);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs, input bit c);
    rq.push_back({c, rs, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) rready <= 1'b0;
      tick();
    end while (rready);
  endtask : rd

  task automatic wait_out();
    n = 0;
    rv = 1'b0;
    while (internalReset) begin
      @(posedge core_clk);
      rv |= resumeAtVector;
      tick();
    end
  endtask : wait_out

  // Result watcher: oldest note against each response
  always @(posedge core_clk) begin
    if (bvalid && bready) begin
      // Popped once so a mismatch report cannot eat a second note
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (rvalid && rready) begin
      e = rq.pop_front();
      lastRd = rdata;
      if (e[34]) begin
        `CHK("rdata", e[31:0], rdata)
        `CHK("rresp", e[33:32], rresp)
      end
    end
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, convStart, converterEnabled} = '0;
    {resetSrcAny, comparatorUsesRef, checked, fail_count} = '0;
    {awaddr, araddr, wdata} = '0;
    reset = 1'b1;
    wstrb = 4'hf;
    startupTimeFuses = 2'h1;
    clockSelFuses = 2'h0;
    brownoutLevelFusesOn = 1'b1;
    comparatorWanted = 1'b1;
    watchdogEnabled = 1'b1;
    wakeInputNeeded = 6'h05;
    void'($urandom(32'h02b9));
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    wait_out();
    `CHK("stretchLen", 1'b1, n >= 3)
    `CHK("vectorPulse", 1'b1, rv)
    rd(8'h00, 32'h0, 2'h0, 1'b1);
    rd(8'h04, 32'h0, 2'h0, 1'b1);
    rd(8'h08, 32'h0, 2'h0, 1'b1);
    rd(8'h0c, 32'h10, 2'h0, 1'b1);
    rd(8'h10, 32'h0, 2'h2, 1'b1);
    wr(8'h10, 8'hff, 2'h2);
    repeat (3) begin
      r = 8'($urandom);
      wr(8'h04, r, 2'h0);
      rd(8'h04, {24'h0, r & 8'h7b}, 2'h0, 1'b1);
      `CHK("pullOff", r[6], pullupGlobalOff)
      `CHK("irqSense", r[1:0], extIrqSense)
    end
    // Timer and converter stay disabled while gated
    for (int g = 0; g < 4; g++) begin
      wr(8'h08, 8'hfc | 8'(g), 2'h0);
      rd(8'h08, 32'(g), 2'h0, 1'b1);
      `CHK("timerClk", !g[1], timerClkEn)
      `CHK("timerAcc", !g[1], timerRegAccessOk)
      `CHK("convClk", !g[0], converterClkEn)
      `CHK("convAcc", !g[0], converterRegAccessOk)
      `CHK("cmpAvail", !g[0], comparatorEnable)
    end
    wr(8'h08, 8'h00, 2'h0);
    convStart <= 1'b1;
    @(posedge core_clk);
    convStart <= 1'b0;
    brownoutLevelFusesOn <= 1'b0;
    @(posedge core_clk);
    rd(8'h0c, 32'h0, 2'h0, 1'b1);
    `CHK("refOff", 1'b0, refEnable)
    `CHK("extConvOff", 1'b0, extendedConvNext)
    converterEnabled <= 1'b1;
    // Let the enable edge land before the status read
    @(posedge core_clk);
    rd(8'h0c, 32'h10, 2'h0, 1'b1);
    `CHK("extConvOn", 1'b1, extendedConvNext)
    `CHK("refOn", 1'b1, refEnable)
    brownoutLevelFusesOn <= 1'b1;
    wakeInputNeeded <= 6'($urandom);
    for (int m = 0; m < 5; m++) begin
      md = 2'(m);
      se = (m < 4);
      slp = se && md != 2'h3;
      wr(8'h04, {2'h0, se, md, 3'h0}, 2'h0);
      core_model_i.sleep_now();
      repeat (2) @(posedge core_clk);
      `CHK("halt", slp, cpuHalt)
      `CHK("cpuClk", !slp, cpuClkEn)
      `CHK("ioClk", !(slp && md != 2'h0), ioClkEn)
      `CHK("osc", !(slp && md == 2'h2), mainOscEn)
      `CHK("inBuf", (slp && md == 2'h2) ? wakeInputNeeded : 6'h3f, inputBufEn)
      `CHK("cmp", !(slp && md == 2'h2), comparatorEnable)
      `CHK("bod", 1'b1, bodEnable)
      `CHK("wdog", 1'b1, watchdogRun)
      rd(8'h0c, 32'h10 | {29'h0, md, 1'b1}, 2'h0, slp);
      core_model_i.wake_now();
      repeat (2) @(posedge core_clk);
      `CHK("awake", 1'b0, cpuHalt)
      wr(8'h04, 8'h00, 2'h0);
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, 8'h03, 2'h0);
      if (k == 1) repeat (8) @(posedge core_clk);
      wr(8'h00, 8'h02, 2'h0);
      seen = 1'b0;
      repeat (4) begin
        rd(8'h0c, 32'h0, 2'h0, 1'b0);
        seen |= lastRd[5];
      end
      `CHK("offSeen", k == 0, seen)
      rd(8'h00, 32'h0, 2'h0, 1'b1);
    end
    // Armed sleep-off carried into a power-down sleep
    comparatorUsesRef <= 1'b1;
    wr(8'h04, 8'h30, 2'h0);
    wr(8'h00, 8'h03, 2'h0);
    wr(8'h00, 8'h02, 2'h0);
    core_model_i.sleep_now();
    repeat (2) @(posedge core_clk);
    `CHK("bodSlept", 1'b0, bodEnable)
    `CHK("cmpRef", 1'b1, comparatorEnable)
    rd(8'h0c, 32'h1d, 2'h0, 1'b1);
    core_model_i.wake_now();
    repeat (2) @(posedge core_clk);
    `CHK("bodBack", 1'b1, bodEnable)
    `CHK("wakeHalt", 1'b1, cpuHalt)
    // Detector settling holds the core for 60 us, 2400 cycles
    repeat (2397) @(posedge core_clk);
    `CHK("wakeHold", 1'b1, cpuHalt)
    repeat (2) @(posedge core_clk);
    `CHK("wakeDone", 1'b0, cpuHalt)
    wr(8'h04, 8'h00, 2'h0);
    wr(8'h04, 8'h41, 2'h0);
    // Slow clock source adds a short span to the stretch
    clockSelFuses <= 2'h2;
    resetSrcAny <= 1'b1;
    #1;
    `CHK("portReset", 1'b1, ioPortReset)
    repeat (2) @(posedge core_clk);
    `CHK("intReset", 1'b1, internalReset)
    resetSrcAny <= 1'b0;
    wait_out();
    `CHK("stretchSlow", 1'b1, n == 9)
    `CHK("vectorAgain", 1'b1, rv)
    rd(8'h04, 32'h0, 2'h0, 1'b1);
    summarize();
  end
endmodule : sleep_power_control_tb
